// ===== core/csl_strap_latch.sv
`default_nettype none
module csl_strap_latch
	import csl_pkg::*;
#(
	parameter int HARD_WIDTH = 4
) (
	input  wire logic                      clock_in,
	input  wire logic                      rst_n_in,
	input  wire logic [HARD_WIDTH-1:0]     hard_straps_in,
	input  wire logic [CSL_MODE_WIDTH-1:0] port1_interface_mode_in,
	input  wire logic                      auto_mdix_strap_in,
	input  wire logic                      manual_mdix_strap_in,
	input  wire logic                      autoneg_strap_in,
	input  wire logic                      port1_heartbeat_off_strap_in,
	input  wire logic                      digital_reset_in,
	input  wire logic                      reload_cmd_in,
	input  wire logic                      eeprom_present_in,
	input  wire logic                      loader_valid_in,
	input  wire logic [CSL_IMG_WIDTH-1:0]  loader_image_in,
	input  wire logic                      crossover_control_select_in,
	output logic                           loader_start_out,
	output logic                           straps_ready_out,
	output logic [HARD_WIDTH-1:0]          hard_straps_out,
	output logic [CSL_LED_COUNT-1:0]       led_enable_bits_out,
	output logic [CSL_LED_FUN_WIDTH-1:0]   led_function_field_out,
	output logic                           auto_mdix_state_out,
	output logic                           mdix_auto_out,
	output logic                           mdix_crossed_out,
	output logic                           phy_autoneg_enable_bit_out,
	output logic                           heartbeat_test_off_bit_out
);

	// The block keeps a copy of every strap that the rest of the device reads at start-up.
	// Straps come in two kinds: hard ones, which only the pins can set, and soft ones,
	// which the EEPROM loader may replace once the pins have been captured.
	// Soft straps that have no pin of their own take fixed tie-off values instead.
	//
	// Every strap pin is asynchronous to the clock, so it passes three flip-flops.
	// The pins are trusted only once stages two and three have agreed for a few cycles.
	// This keeps a pin that is still settling after reset from being captured.
	//
	// Capture happens exactly once after each release of the asynchronous reset.
	// That reset stands for both the power-on reset and the external reset pin.
	// After capture the pin image is frozen; later pin activity is ignored.
	// The only way to capture new pin values is another assertion of that reset.
	//
	// Two copies of the soft strap image are kept.
	// The latched copy always holds the pin image taken at the last capture.
	// The active copy is what the outputs show, and the loader may overwrite it.
	// Keeping both lets a later request fall back without looking at the pins again.
	//
	// A digital reset or a reload command first restores the latched copy.
	// The loader is then started again, so any EEPROM contents are reapplied.
	// Without a usable EEPROM the wait ends at once and the latched copy stays.
	// Requests that arrive while the loader is busy are ignored, not queued.
	//
	// The ready output is low from the request until the image is final.
	// Consumers should only read the defaults while the ready output is high.
	// The loader start output is a single-cycle pulse for each loader run.
	//
	// Soft strap outputs come in two flavours.
	// Straps that configure a bit are copied straight from the active image.
	// Straps that only affect a bit are combined with the captured port mode.
	// The crossover outputs also depend on the live strap-control select input.
	// Crossover straps are ignored in the external interface modes of port 1.
	// The autoneg default is only honoured in the internal PHY mode.
	// The heartbeat-off default is only honoured in the MII PHY mode.
	//
	// Hazards and limits.
	// The loader image is only taken while the block waits for it.
	// A loader answer outside that window is dropped without notice.
	// An EEPROM that never answers while marked present keeps ready low for good.
	// The port mode is captured with the straps and never changes afterwards.
	// Mode codes outside the four known ones behave like the internal PHY mode
	// for crossover, but give autoneg and heartbeat-off defaults of zero.
	// Every output is registered, so results lag the internal state by one cycle.

	// Positions of each strap inside the synchronised pin word.
	localparam int PIN_HB_POS   = 0;
	localparam int PIN_AN_POS   = 1;
	localparam int PIN_MAN_POS  = 2;
	localparam int PIN_AUTO_POS = 3;
	localparam int PIN_MODE_LSB = 4;
	// Last count of the agreement window before the pins are trusted.
	localparam logic [1:0] SETTLE_LAST = 2'h3;

	// Pin synchronisers, three stages per strap pin and mode pin.
	localparam int PW = HARD_WIDTH + CSL_MODE_WIDTH + PIN_MODE_LSB;
	logic [PW-1:0] pin_raw;
	logic [PW-1:0] s1_reg, s2_reg, s3_reg;
	assign pin_raw = {hard_straps_in, port1_interface_mode_in, auto_mdix_strap_in,
		manual_mdix_strap_in, autoneg_strap_in, port1_heartbeat_off_strap_in};

	// Capture sequencing state.
	logic [1:0]                  settle_reg, settle_next;
	logic                        captured_reg, captured_next;
	logic [HARD_WIDTH-1:0]       hard_reg, hard_next;
	logic [CSL_MODE_WIDTH-1:0]   mode_reg, mode_next;
	logic [CSL_IMG_WIDTH-1:0]    latched_reg, latched_next;
	logic [CSL_IMG_WIDTH-1:0]    active_reg, active_next;
	csl_state_t                  state_reg, state_next;
	logic                        start_reg, start_next;
	logic                        ready_reg, ready_next;
	logic [CSL_IMG_WIDTH-1:0]    pin_img;
	logic                        mode_mii_family;

	// Builds a soft-strap image; pinless straps take tie-offs.
	function automatic logic [CSL_IMG_WIDTH-1:0] build_image(
		input logic auto_mdix,
		input logic man_mdix,
		input logic autoneg,
		input logic hb_off
	);
		logic [CSL_IMG_WIDTH-1:0] img;
		img = '0;
		img[CSL_IMG_LED_EN_LSB +: CSL_LED_COUNT]      = CSL_LED_EN_DEFAULT;
		img[CSL_IMG_LED_FUN_LSB +: CSL_LED_FUN_WIDTH] = CSL_LED_FUN_DEFAULT;
		img[CSL_IMG_AUTO_MDIX] = auto_mdix;
		img[CSL_IMG_MAN_MDIX]  = man_mdix;
		img[CSL_IMG_AUTONEG]   = autoneg;
		img[CSL_IMG_HEARTBEAT] = hb_off;
		return img;
	endfunction

	// Soft strap image as the synchronised pins show it now.
	assign pin_img = build_image(s3_reg[PIN_AUTO_POS], s3_reg[PIN_MAN_POS],
		s3_reg[PIN_AN_POS], s3_reg[PIN_HB_POS]);

	// Synchroniser chain; stage one feeds only stage two.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= pin_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Next-state logic for capture, override and loader sequencing.
	always_comb begin
		settle_next   = settle_reg;
		captured_next = captured_reg;
		hard_next     = hard_reg;
		mode_next     = mode_reg;
		latched_next  = latched_reg;
		active_next   = active_reg;
		state_next    = state_reg;
		start_next    = 1'b0;
		ready_next    = ready_reg;
		if (!captured_reg) begin
			// Wait until stages two and three agree for four cycles after release.
			if (s2_reg != s3_reg) begin
				settle_next = '0;
			end else if (settle_reg != SETTLE_LAST) begin
				settle_next = settle_reg + 2'h1;
			end else begin
				captured_next = 1'b1;
				hard_next     = s3_reg[PW-1 -: HARD_WIDTH];
				mode_next     = s3_reg[PIN_MODE_LSB +: CSL_MODE_WIDTH];
				latched_next  = pin_img;
				active_next   = pin_img;
				start_next    = 1'b1;
				state_next    = CSL_ST_WAIT;
			end
		end else begin
			unique case (state_reg)
				CSL_ST_IDLE, CSL_ST_DONE: begin
					if (digital_reset_in || reload_cmd_in) begin
						active_next = latched_reg;
						ready_next  = 1'b0;
						start_next  = 1'b1;
						state_next  = CSL_ST_WAIT;
					end
				end
				CSL_ST_WAIT: begin
					if (loader_valid_in) begin
						if (eeprom_present_in) begin
							active_next = loader_image_in;
						end
						ready_next = 1'b1;
						state_next = CSL_ST_DONE;
					end else if (!eeprom_present_in) begin
						ready_next = 1'b1;
						state_next = CSL_ST_DONE;
					end
				end
				default: state_next = CSL_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_reg   <= '0;
			captured_reg <= 1'b0;
			hard_reg     <= '0;
			mode_reg     <= '0;
			latched_reg  <= '0;
			active_reg   <= '0;
			state_reg    <= CSL_ST_IDLE;
			start_reg    <= 1'b0;
			ready_reg    <= 1'b0;
		end else begin
			settle_reg   <= settle_next;
			captured_reg <= captured_next;
			hard_reg     <= hard_next;
			mode_reg     <= mode_next;
			latched_reg  <= latched_next;
			active_reg   <= active_next;
			state_reg    <= state_next;
			start_reg    <= start_next;
			ready_reg    <= ready_next;
		end
	end

	assign mode_mii_family = (mode_reg == CSL_MODE_MII_PHY) ||
		(mode_reg == CSL_MODE_RMII_PHY) || (mode_reg == CSL_MODE_MII_MAC);

	// Output register computation.
	logic [CSL_LED_COUNT-1:0]     led_en_next;
	logic [CSL_LED_FUN_WIDTH-1:0] led_fun_next;
	logic                         amdix_state_next, mdix_auto_next, mdix_cross_next;
	logic                         an_next, hb_next;

	always_comb begin
		led_en_next      = active_reg[CSL_IMG_LED_EN_LSB +: CSL_LED_COUNT];
		led_fun_next     = active_reg[CSL_IMG_LED_FUN_LSB +: CSL_LED_FUN_WIDTH];
		amdix_state_next = active_reg[CSL_IMG_AUTO_MDIX];
		mdix_auto_next   = 1'b0;
		mdix_cross_next  = CSL_MDI_STRAIGHT;
		if (crossover_control_select_in && !mode_mii_family) begin
			mdix_auto_next = active_reg[CSL_IMG_AUTO_MDIX];
			if (!active_reg[CSL_IMG_AUTO_MDIX]) begin
				mdix_cross_next = active_reg[CSL_IMG_MAN_MDIX] ? CSL_MDIX_CROSSED
					: CSL_MDI_STRAIGHT;
			end
		end
		an_next = (mode_reg == CSL_MODE_INTERNAL_PHY) && active_reg[CSL_IMG_AUTONEG];
		hb_next = (mode_reg == CSL_MODE_MII_PHY) ? active_reg[CSL_IMG_HEARTBEAT]
			: CSL_HEARTBEAT_OFF_DEF;
	end

	// Registered outputs.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			loader_start_out           <= 1'b0;
			straps_ready_out           <= 1'b0;
			hard_straps_out            <= '0;
			led_enable_bits_out        <= '0;
			led_function_field_out     <= '0;
			auto_mdix_state_out        <= 1'b0;
			mdix_auto_out              <= 1'b0;
			mdix_crossed_out           <= 1'b0;
			phy_autoneg_enable_bit_out <= 1'b0;
			heartbeat_test_off_bit_out <= 1'b0;
		end else begin
			loader_start_out           <= start_reg;
			straps_ready_out           <= ready_reg;
			hard_straps_out            <= hard_reg;
			led_enable_bits_out        <= led_en_next;
			led_function_field_out     <= led_fun_next;
			auto_mdix_state_out        <= amdix_state_next;
			mdix_auto_out              <= mdix_auto_next;
			mdix_crossed_out           <= mdix_cross_next;
			phy_autoneg_enable_bit_out <= an_next;
			heartbeat_test_off_bit_out <= hb_next;
		end
	end

endmodule
`default_nettype wire

// ===== include/csl_pkg.sv
`default_nettype none
package csl_pkg;
	// Soft-strap tie-off defaults used when no pin backs the strap.
	localparam int          CSL_LED_COUNT        = 6;
	localparam int          CSL_LED_FUN_WIDTH    = 2;
	localparam int          CSL_MODE_WIDTH       = 3;
	localparam logic [5:0]  CSL_LED_EN_DEFAULT   = 6'h3F;
	localparam logic [1:0]  CSL_LED_FUN_DEFAULT  = 2'h0;
	localparam logic        CSL_MANUAL_MDIX_DEF  = 1'h0;
	localparam logic        CSL_HEARTBEAT_OFF_DEF = 1'h0;
	// Port 1 interface modes.
	localparam logic [2:0]  CSL_MODE_INTERNAL_PHY = 3'h7;
	localparam logic [2:0]  CSL_MODE_MII_PHY      = 3'h1;
	localparam logic [2:0]  CSL_MODE_RMII_PHY     = 3'h2;
	localparam logic [2:0]  CSL_MODE_MII_MAC      = 3'h0;
	// Crossover settings.
	localparam logic        CSL_MDI_STRAIGHT = 1'h0;
	localparam logic        CSL_MDIX_CROSSED = 1'h1;
	// Soft-strap image bit positions.
	localparam int          CSL_IMG_LED_EN_LSB  = 0;
	localparam int          CSL_IMG_LED_FUN_LSB = 6;
	localparam int          CSL_IMG_AUTO_MDIX   = 8;
	localparam int          CSL_IMG_MAN_MDIX    = 9;
	localparam int          CSL_IMG_AUTONEG     = 10;
	localparam int          CSL_IMG_HEARTBEAT   = 11;
	localparam int          CSL_IMG_WIDTH       = 12;
	// Loader phases.
	typedef enum logic [2:0] {
		CSL_ST_IDLE = 3'h1,
		CSL_ST_WAIT = 3'h2,
		CSL_ST_DONE = 3'h4
	} csl_state_t;
endpackage
`default_nettype wire

// ===== tb/csl_strap_latch_checker.sv
`default_nettype none
module csl_strap_latch_checker
	import csl_pkg::*;
#(
	parameter int HARD_WIDTH = 4
) (
	input wire logic                  clock_in,
	input wire logic                  rst_n_in,
	input wire logic [2:0]            port1_interface_mode_in,
	input wire logic                  digital_reset_in,
	input wire logic                  reload_cmd_in,
	input wire logic                  eeprom_present_in,
	input wire logic                  loader_valid_in,
	input wire logic [11:0]           loader_image_in,
	input wire logic                  crossover_control_select_in,
	input wire logic                  loader_start_out,
	input wire logic                  straps_ready_out,
	input wire logic [HARD_WIDTH-1:0] hard_straps_out,
	input wire logic [5:0]            led_enable_bits_out,
	input wire logic                  auto_mdix_state_out,
	input wire logic                  mdix_auto_out,
	input wire logic                  mdix_crossed_out,
	input wire logic                  phy_autoneg_enable_bit_out,
	input wire logic                  heartbeat_test_off_bit_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        started_reg;
	logic [2:0]  mode_reg;
	logic [11:0] img_reg;
	logic        req;
	logic        mii_fam;
	// Mode is remembered up to the first loader start; the last loader image is kept.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			started_reg <= 1'h0;
			mode_reg <= 3'h0;
			img_reg <= 12'h000;
		end else begin
			if (!started_reg) started_reg <= loader_start_out;
			if (!started_reg) mode_reg <= port1_interface_mode_in;
			if (loader_valid_in) img_reg <= loader_image_in;
		end
	end
	// Request and mode group decodes.
	assign req = digital_reset_in | reload_cmd_in;
	assign mii_fam = mode_reg inside {CSL_MODE_MII_MAC, CSL_MODE_MII_PHY, CSL_MODE_RMII_PHY};
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	chk_start_pulse:
		assert property (loader_start_out |=> !loader_start_out) else $error("start too long");
	chk_req_restart:
		assert property (straps_ready_out && req |-> ##2 loader_start_out && !straps_ready_out)
			else $error("request not answered");
	chk_hard_hold:
		assert property (started_reg && $past(started_reg) |-> $stable(hard_straps_out))
			else $error("hard straps moved");
	chk_load_apply:
		assert property (!straps_ready_out && loader_valid_in && eeprom_present_in && started_reg
			|-> ##2 straps_ready_out && led_enable_bits_out == img_reg[5:0]) else $error("no load");
	chk_absent_finish:
		assert property (loader_start_out && !eeprom_present_in |-> ##[1:4] straps_ready_out)
			else $error("absent wait hangs");
	chk_autoneg_mode:
		assert property (phy_autoneg_enable_bit_out |-> mode_reg == CSL_MODE_INTERNAL_PHY)
			else $error("autoneg in wrong mode");
	chk_heartbeat_mode:
		assert property (heartbeat_test_off_bit_out |-> mode_reg == CSL_MODE_MII_PHY)
			else $error("heartbeat bit in wrong mode");
	chk_mdix_ignore:
		assert property (mii_fam || !crossover_control_select_in |-> !mdix_auto_out && !mdix_crossed_out)
			else $error("crossover not ignored");
	chk_mdix_follow:
		assert property (straps_ready_out && !mii_fam && crossover_control_select_in
			|-> mdix_auto_out == auto_mdix_state_out) else $error("auto crossover wrong");
	// Main scenarios reached.
	cover property (straps_ready_out && req);
	cover property (loader_valid_in && eeprom_present_in);
	cover property (heartbeat_test_off_bit_out);
endmodule
bind csl_strap_latch csl_strap_latch_checker #(.HARD_WIDTH(HARD_WIDTH)) u_chk (.*);
`default_nettype wire

// ===== tb/csl_eeprom_model.sv
`default_nettype none
module csl_eeprom_model (
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	input  wire logic        loader_start_out,
	input  wire logic        eeprom_present_in,
	input  wire logic [11:0] ee_image,
	input  wire logic [3:0]  ee_delay,
	output logic             loader_valid_in,
	output logic [11:0]      loader_image_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0]  wait_reg;
	logic [11:0] noise_reg;
	// Answers a loader start after a set delay, only when a part is fitted.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_reg <= 5'h00;
			noise_reg <= 12'h000;
		end else begin
			noise_reg <= noise_reg + 12'h9E3;
			if (loader_start_out && eeprom_present_in) wait_reg <= {1'h0, ee_delay} + 5'h01;
			else if (wait_reg != 5'h00) wait_reg <= wait_reg - 5'h01;
		end
	end
	// Data lines show a moving pattern outside the one valid cycle.
	assign loader_valid_in = wait_reg == 5'h01;
	assign loader_image_in = loader_valid_in ? ee_image : noise_reg;
endmodule
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import csl_pkg::*;
	logic clock_in = 1'h0, rst_n_in = 1'h0, digital_reset_in = 1'h0, reload_cmd_in = 1'h0;
	logic auto_mdix_strap_in = 1'h0, manual_mdix_strap_in = 1'h0, autoneg_strap_in = 1'h0;
	logic port1_heartbeat_off_strap_in = 1'h0, eeprom_present_in = 1'h0;
	logic crossover_control_select_in = 1'h0, loader_valid_in, straps_ready_out;
	logic loader_start_out, auto_mdix_state_out, mdix_auto_out, mdix_crossed_out;
	logic phy_autoneg_enable_bit_out, heartbeat_test_off_bit_out;
	logic [3:0]  hard_straps_in = 4'h0, hard_straps_out, ee_delay = 4'h0, hs;
	logic [2:0]  port1_interface_mode_in = 3'h0;
	logic [11:0] loader_image_in, ee_image = 12'h000, pin_img;
	logic [5:0]  led_enable_bits_out;
	logic [1:0]  led_function_field_out;
	logic [2:0]  modes [4] = '{CSL_MODE_MII_MAC, CSL_MODE_MII_PHY, CSL_MODE_RMII_PHY, CSL_MODE_INTERNAL_PHY};
	int seed, n_mismatch, n_compared, i, k;
	csl_strap_latch DUT (.*);
	csl_eeprom_model u_eeprom (.*);
	// Free running 100 MHz clock.
	always #5 clock_in = ~clock_in;
	// Expected outputs from the captured straps, the active image, mode and select.
	function automatic logic [16:0] expect_out(input logic [3:0] h, input logic [11:0] im,
			input logic [2:0] md, input logic s);
		logic en;
		en = s && md == CSL_MODE_INTERNAL_PHY;
		return {h, im[7:0], im[8], en & im[8], en & ~im[8] & im[9],
			im[10] & (md == CSL_MODE_INTERNAL_PHY), im[11] & (md == CSL_MODE_MII_PHY)};
	endfunction
	task automatic compare(input logic [16:0] e);
		logic [16:0] g;
		g = {hard_straps_out, led_function_field_out, led_enable_bits_out, auto_mdix_state_out,
			mdix_auto_out, mdix_crossed_out, phy_autoneg_enable_bit_out, heartbeat_test_off_bit_out};
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: outputs %h expected %h", $time, g, e);
		end
	endtask
	task automatic wait_ready(input logic lvl);
		int c;
		c = 0;
		while (straps_ready_out !== lvl && c < 100) begin
			@(posedge clock_in);
			#1 c++;
		end
		if (c == 100) begin
			n_mismatch++;
			$display("mismatch at %0t: ready never reached %b", $time, lvl);
		end
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Pin resets through every mode, each followed by a digital reset and a reload.
	initial begin
		seed = 62298;
		for (i = 0; i < 12; i++) begin
			rst_n_in = 1'h0;
			hard_straps_in = 4'($random(seed));
			port1_interface_mode_in = modes[i % 4];
			{auto_mdix_strap_in, manual_mdix_strap_in, autoneg_strap_in,
				port1_heartbeat_off_strap_in} = 4'($random(seed));
			{crossover_control_select_in, eeprom_present_in} = i < 2 ? 2'h3 : 2'($random(seed));
			ee_image = 12'($random(seed));
			ee_delay = 4'($random(seed));
			hs = hard_straps_in;
			pin_img = {port1_heartbeat_off_strap_in, autoneg_strap_in, manual_mdix_strap_in,
				auto_mdix_strap_in, CSL_LED_FUN_DEFAULT, CSL_LED_EN_DEFAULT};
			repeat (12) @(posedge clock_in);
			#1 rst_n_in = 1'h1;
			wait_ready(1'h1);
			compare(expect_out(hs, eeprom_present_in ? ee_image : pin_img,
				port1_interface_mode_in, crossover_control_select_in));
			for (k = 0; k < 2; k++) begin
				{hard_straps_in, auto_mdix_strap_in, manual_mdix_strap_in, autoneg_strap_in,
					port1_heartbeat_off_strap_in} = 8'($random(seed));
				eeprom_present_in = k == 0 && i < 2 ? 1'h0 : 1'($random(seed));
				ee_image = 12'($random(seed));
				{digital_reset_in, reload_cmd_in} = k ? 2'h1 : 2'h2;
				@(posedge clock_in);
				#1 {digital_reset_in, reload_cmd_in} = 2'h0;
				wait_ready(1'h0);
				wait_ready(1'h1);
				compare(expect_out(hs, eeprom_present_in ? ee_image : pin_img,
					port1_interface_mode_in, crossover_control_select_in));
			end
		end
		complete_run;
	end
	// Cuts a hang short.
	initial begin
		#200000;
		n_mismatch++;
		complete_run;
	end
endmodule
`default_nettype wire
